// file: inc/bitc_regs.svh
// Purpose: offsets, field positions and reset values of the register window
// Assumes: 16-location I/O window, 16-bit data path
// Notes: definitions only
`ifndef BITC_REGS_SVH
`define BITC_REGS_SVH

// ----------------------------------------------------------------------
// offsets within the window
// ----------------------------------------------------------------------
`define BITC_OFF_TRANSMIT_CONTROL 4'h0
`define BITC_OFF_BANK_SELECTOR 4'hE

// ----------------------------------------------------------------------
// bank selector fields
// ----------------------------------------------------------------------
`define BITC_BANK_SIGNATURE 8'h33
`define BITC_BANK_SEL_RESET 3'h0
`define BITC_BANK_SEL_TOP 2

// ----------------------------------------------------------------------
// transmit control fields
// ----------------------------------------------------------------------
`define BITC_TC_TRANSMIT_ENABLE 0
`define BITC_TC_LOCAL_LOOPBACK 1
`define BITC_TC_FORCE_COLLISION 2
`define BITC_TC_PAD_ENABLE 7
`define BITC_TC_SUPPRESS_CRC 8
`define BITC_TC_CARRIER_MONITOR 10
`define BITC_TC_FULL_DUPLEX 11
`define BITC_TC_STOP_QUALITY 12
`define BITC_TC_BLOCK_LOOPBACK 13
`define BITC_TC_SWITCHED_DUPLEX 15
`define BITC_TC_WRITE_MASK 16'hBD87
`define BITC_TC_RESET 16'h0000

// ----------------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------------
`define BITC_MIN_FRAME_BYTES 7'h40
`define BITC_COLLISION_LIMIT 5'h10

`endif

// file: inc/bitc_pkg.sv
// Purpose: shared types of the banked window and transmit control
// Assumes: nothing beyond the register header
// Notes: types only
package bitc_pkg;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_SEND = 4'h2,
		TX_PAD = 4'h4,
		TX_HALT = 4'h8
	} bitc_tx_state_type;

endpackage

// file: src/bitc_top.sv
// Purpose: banked host I/O window and transmit control of a 10 Mb/s MAC
// Assumes: host strobes are asynchronous and pass two flip-flops
// Notes: only bank 0 offset 0 and the shared selector are held here
//
// What this block does
// - ISA cycles claimed only when A4-A15 match base
// - PCMCIA access marked by select plus strobe
// - sixteen locations; last word selects bank
// - offset even byte or word; odd byte plus one
// - word and byte access to every register
// - selector always reachable except PCMCIA powerdown
// - selector upper byte reads constant 33h
// - ISA has banks 0-3 only; PCMCIA six banks
// - switched duplex: no deferral, forced duplex
// - block loopback returns data, nothing sent
// - quality error halts transmitter when stop set
// - full duplex accepts self-sourced frames
// - carrier monitor aborts without CRC, disables
// - CRC appended unless suppress bit set
// - pad short frames to 64 bytes
// - force collision skips deferral, self clears
// - local loopback after encoder, nothing sent
// - transmit enable clear finishes frame first
// - sixteen collisions clear enable, flag held
`include "bitc_regs.svh"

module bitc_top
	import bitc_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RESET,
	// host bus
	input wire logic I_PCMCIA_MODE,
	input wire logic I_POWERDOWN,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic I_REGISTER_SPACE_SELECT_N,
	input wire logic I_IO_READ_STROBE_N,
	input wire logic I_IO_WRITE_STROBE_N,
	input wire logic I_BYTE_EN_HIGH,
	input wire logic I_BYTE_EN_LOW,
	input wire logic [15:0] I_WDATA,
	input wire logic [11:0] I_BASE_ADDR,
	output logic [15:0] O_RDATA,
	output logic O_RDATA_OE,
	// transmit engine
	input wire logic I_FRAME_READY,
	input wire logic I_FRAME_BYTE_DONE,
	input wire logic I_FRAME_LAST,
	input wire logic I_CARRIER,
	input wire logic I_PREAMBLE_END,
	input wire logic I_COLLISION,
	input wire logic I_LATE_COLLISION,
	input wire logic I_QUALITY_FAIL,
	input wire logic I_SELF_SOURCED,
	output logic O_TX_ACTIVE,
	output logic O_TX_PAD_ZERO,
	output logic O_APPEND_CRC,
	output logic O_ABORT_NO_CRC,
	output logic O_SKIP_DEFER,
	output logic O_COLLISION_DETECT,
	output logic O_LOOP_BLOCK,
	output logic O_LOOP_ENDEC,
	output logic O_NET_TX_ENABLE,
	output logic O_ACCEPT_SELF,
	output logic O_SIXTEEN_COLLISION_FLAG,
	output logic O_LATE_COLLISION_FLAG
);

	if (ADDR_W < 5) begin : g_addr_check
		$error("address must cover the window and base");
	end

	// ------------------------------------------------------------------
	// strobe synchronisers
	// ------------------------------------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic rd_prev_q;
	logic wr_prev_q;
	logic rd_s;
	logic wr_s;
	logic sel_s;
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end else begin
			sync1_q <= {I_REGISTER_SPACE_SELECT_N, I_IO_READ_STROBE_N,
				I_IO_WRITE_STROBE_N};
			sync2_q <= sync1_q;
		end
	end
	assign sel_s = ~sync2_q[2];
	assign rd_s = ~sync2_q[1];
	assign wr_s = ~sync2_q[0];

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= rd_s;
			wr_prev_q <= wr_s;
		end
	end

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	// address and data are held stable by the host across the strobe,
	// so they are sampled only once the strobe has crossed over
	logic claim;
	logic [3:0] offs;
	logic [2:0] bank_sel_bits_q;
	logic bank_ok;
	logic sel_ok;
	logic tc_hit;
	logic bs_hit;
	logic wr_pulse;
	always_comb begin
		offs = I_ADDR[3:0];
		if (I_PCMCIA_MODE)
			claim = sel_s;
		else
			claim = I_ADDR[ADDR_W-1:4] == (ADDR_W-4)'(I_BASE_ADDR);
		sel_ok = claim && !(I_PCMCIA_MODE && I_POWERDOWN);
		// ISA has banks 0-3 only; bank 6 and 7 never exist
		bank_ok = I_PCMCIA_MODE ? (bank_sel_bits_q < 3'h6) :
			!bank_sel_bits_q[`BITC_BANK_SEL_TOP];
		bs_hit = sel_ok &&
			offs[3:1] == 3'(`BITC_OFF_BANK_SELECTOR >> 1);
		tc_hit = sel_ok && bank_ok && bank_sel_bits_q == 3'h0 &&
			offs[3:1] == 3'(`BITC_OFF_TRANSMIT_CONTROL >> 1);
	end
	assign wr_pulse = wr_s && !wr_prev_q;

	// ------------------------------------------------------------------
	// byte lane selection
	// ------------------------------------------------------------------
	// odd offset reaches the high byte alone; even offset with both
	// enables makes a word access
	logic lane_hi;
	logic lane_lo;
	always_comb begin
		lane_hi = offs[0] || I_BYTE_EN_HIGH;
		lane_lo = !offs[0] && I_BYTE_EN_LOW;
	end

	// ------------------------------------------------------------------
	// bank selector
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RESET)
			bank_sel_bits_q <= `BITC_BANK_SEL_RESET;
		else if (wr_pulse && bs_hit && lane_lo)
			bank_sel_bits_q <= I_WDATA[2:0];
	end

	// ------------------------------------------------------------------
	// transmit control register
	// ------------------------------------------------------------------
	localparam logic [15:0] TC_MASK = `BITC_TC_WRITE_MASK;
	logic [15:0] tc_q;
	logic sixteen_q;
	logic late_q;
	logic enable_set;
	logic err_halt;
	logic fc_done;
	logic [4:0] coll_cnt_q;
	bitc_tx_state_type st_q;
	logic duplex_eff;
	logic monitor_eff;
	logic carrier_lost;

	assign enable_set = wr_pulse && tc_hit && lane_lo &&
		I_WDATA[`BITC_TC_TRANSMIT_ENABLE];
	always_comb begin
		duplex_eff = tc_q[`BITC_TC_FULL_DUPLEX] ||
			tc_q[`BITC_TC_SWITCHED_DUPLEX];
		monitor_eff = tc_q[`BITC_TC_CARRIER_MONITOR] &&
			!tc_q[`BITC_TC_SWITCHED_DUPLEX];
		carrier_lost = st_q == TX_SEND && monitor_eff &&
			!I_CARRIER && (I_PREAMBLE_END || I_FRAME_BYTE_DONE);
		err_halt = st_q == TX_SEND && (carrier_lost || I_LATE_COLLISION ||
			(I_QUALITY_FAIL && tc_q[`BITC_TC_STOP_QUALITY]) ||
			(I_COLLISION && coll_cnt_q == `BITC_COLLISION_LIMIT - 5'h1));
		fc_done = st_q == TX_SEND && I_COLLISION;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET)
			tc_q <= `BITC_TC_RESET;
		else begin
			if (wr_pulse && tc_hit) begin
				if (lane_lo)
					tc_q[7:0] <= I_WDATA[7:0] & TC_MASK[7:0];
				if (lane_hi)
					tc_q[15:8] <= (offs[0] ? I_WDATA[7:0] :
						I_WDATA[15:8]) & TC_MASK[15:8];
			end
			if (fc_done)
				tc_q[`BITC_TC_FORCE_COLLISION] <= 1'b0;
			if (err_halt)
				tc_q[`BITC_TC_TRANSMIT_ENABLE] <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// error flags, cleared by re-enabling transmit
	// ------------------------------------------------------------------
	// a fresh error in the same cycle as the enable write wins
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			sixteen_q <= 1'b0;
			late_q <= 1'b0;
		end else begin
			if (st_q == TX_SEND && I_COLLISION &&
				coll_cnt_q == `BITC_COLLISION_LIMIT - 5'h1)
				sixteen_q <= 1'b1;
			else if (enable_set)
				sixteen_q <= 1'b0;
			if (st_q == TX_SEND && I_LATE_COLLISION)
				late_q <= 1'b1;
			else if (enable_set)
				late_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// transmit sequencer
	// ------------------------------------------------------------------
	logic [6:0] byte_cnt_q;
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			st_q <= TX_IDLE;
			byte_cnt_q <= 7'h0;
			coll_cnt_q <= 5'h0;
		end else begin
			case (st_q)
			TX_IDLE: begin
				byte_cnt_q <= 7'h0;
				coll_cnt_q <= 5'h0;
				if (tc_q[`BITC_TC_TRANSMIT_ENABLE] && I_FRAME_READY)
					st_q <= TX_SEND;
			end
			TX_SEND: begin
				if (I_COLLISION)
					coll_cnt_q <= coll_cnt_q + 5'h1;
				if (I_FRAME_BYTE_DONE && byte_cnt_q != 7'h7F)
					byte_cnt_q <= byte_cnt_q + 7'h1;
				if (err_halt)
					st_q <= TX_HALT;
				else if (I_FRAME_LAST && I_FRAME_BYTE_DONE) begin
					if (tc_q[`BITC_TC_PAD_ENABLE] &&
						byte_cnt_q + 7'h1 < `BITC_MIN_FRAME_BYTES)
						st_q <= TX_PAD;
					else
						st_q <= TX_IDLE;
				end
			end
			TX_PAD: begin
				if (I_FRAME_BYTE_DONE) begin
					byte_cnt_q <= byte_cnt_q + 7'h1;
					if (byte_cnt_q + 7'h1 >= `BITC_MIN_FRAME_BYTES)
						st_q <= TX_IDLE;
				end
			end
			TX_HALT:
				st_q <= TX_IDLE;
			default:
				st_q <= TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_TX_ACTIVE <= 1'b0;
			O_TX_PAD_ZERO <= 1'b0;
			O_APPEND_CRC <= 1'b1;
			O_ABORT_NO_CRC <= 1'b0;
			O_SKIP_DEFER <= 1'b0;
			O_COLLISION_DETECT <= 1'b1;
			O_LOOP_BLOCK <= 1'b0;
			O_LOOP_ENDEC <= 1'b0;
			O_NET_TX_ENABLE <= 1'b1;
			O_ACCEPT_SELF <= 1'b0;
			O_SIXTEEN_COLLISION_FLAG <= 1'b0;
			O_LATE_COLLISION_FLAG <= 1'b0;
		end else begin
			O_TX_ACTIVE <= st_q == TX_SEND || st_q == TX_PAD;
			O_TX_PAD_ZERO <= st_q == TX_PAD;
			O_APPEND_CRC <= !tc_q[`BITC_TC_SUPPRESS_CRC];
			O_ABORT_NO_CRC <= carrier_lost;
			O_SKIP_DEFER <= tc_q[`BITC_TC_SWITCHED_DUPLEX] ||
				tc_q[`BITC_TC_FORCE_COLLISION];
			// local loopback and switched duplex turn off collision detect
			O_COLLISION_DETECT <= !tc_q[`BITC_TC_SWITCHED_DUPLEX] &&
				!tc_q[`BITC_TC_LOCAL_LOOPBACK];
			O_LOOP_BLOCK <= tc_q[`BITC_TC_BLOCK_LOOPBACK];
			// block loopback overrides local loopback
			O_LOOP_ENDEC <= tc_q[`BITC_TC_LOCAL_LOOPBACK] &&
				!tc_q[`BITC_TC_BLOCK_LOOPBACK];
			O_NET_TX_ENABLE <= !tc_q[`BITC_TC_BLOCK_LOOPBACK] &&
				!tc_q[`BITC_TC_LOCAL_LOOPBACK];
			O_ACCEPT_SELF <= duplex_eff && I_SELF_SOURCED;
			O_SIXTEEN_COLLISION_FLAG <= sixteen_q;
			O_LATE_COLLISION_FLAG <= late_q;
		end
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	// is the host's duty: a soft reset elsewhere clears the path
	logic [15:0] rd_word;
	always_comb begin
		rd_word = 16'h0000;
		if (bs_hit)
			rd_word = {`BITC_BANK_SIGNATURE, 5'h00, bank_sel_bits_q};
		else if (tc_hit)
			rd_word = tc_q;
		if (offs[0])
			rd_word = {8'h00, rd_word[15:8]};
	end
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_RDATA <= 16'h0000;
			O_RDATA_OE <= 1'b0;
		end else begin
			O_RDATA <= rd_word;
			O_RDATA_OE <= rd_s && (bs_hit || tc_hit);
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sig_read_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		rd_s && bs_hit && !offs[0] |=> O_RDATA[15:8] == 8'h33)
		else $error("selector upper byte not 33h");
	bank_reset_a: assert property (@(posedge I_CLK)
		I_RESET |=> bank_sel_bits_q == 3'h0)
		else $error("bank bits not zero after reset");
	bank_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		wr_pulse && bs_hit && lane_lo |=>
			bank_sel_bits_q == $past(I_WDATA[2:0]))
		else $error("bank write not taken");
	isa_top_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		!I_PCMCIA_MODE && bank_sel_bits_q[2] |-> !tc_hit)
		else $error("isa decoded a missing bank");
	crc_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		##1 O_APPEND_CRC == !$past(tc_q[8]))
		else $error("crc append wrong");
	halt_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		err_halt |=> !tc_q[0] ##1 st_q == TX_IDLE)
		else $error("enable not cleared on error");
	force_collision_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		fc_done |=> !tc_q[2])
		else $error("force collision not cleared");
	sixteen_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		sixteen_q && !enable_set |=> sixteen_q)
		else $error("sixteen flag dropped early");
	loop_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		tc_q[13] |=> !O_NET_TX_ENABLE && O_LOOP_BLOCK && !O_LOOP_ENDEC)
		else $error("block loopback not exclusive");
	duplex_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
		tc_q[15] |=> O_ACCEPT_SELF == $past(I_SELF_SOURCED) &&
			O_SKIP_DEFER && !O_COLLISION_DETECT)
		else $error("switched duplex not forced");

endmodule

// file: bench/bitc_host_model.sv
// Purpose: host CPU model driving the strobes of the I/O window
// Assumes: strobes pass a two-stage sync, so a write strobe is held six cycles
// Notes: released lines show the inverse of their last value
module bitc_host_model (
	// clock
	input wire logic i_clk,
	// read return
	input wire logic [15:0] i_rdata,
	input wire logic i_rdata_oe,
	// bus drive
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_sel_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_be_h,
	output logic o_be_l
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
		o_sel_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_be_h = 1'b0;
		o_be_l = 1'b0;
	end

	task automatic start(input logic [15:0] a, d, input logic bh, bl);
		@(posedge i_clk);
		#2;
		o_addr = a;
		o_wdata = d;
		o_be_h = bh;
		o_be_l = bl;
		o_sel_n = 1'b0;
	endtask

	// the gap covers the synchroniser and the read enable tail
	task automatic finish_cycle();
		@(posedge i_clk);
		#2;
		o_sel_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
		repeat (6) @(posedge i_clk);
	endtask

	task automatic io_write(input logic [15:0] a, d, input logic bh, bl);
		start(a, d, bh, bl);
		o_wr_n = 1'b0;
		repeat (5) @(posedge i_clk);
		finish_cycle();
	endtask

	task automatic io_read(input logic [15:0] a, output logic [15:0] d,
		output logic ok);
		start(a, 16'h0000, 1'b1, 1'b1);
		o_rd_n = 1'b0;
		ok = 1'b0;
		d = 16'h0000;
		for (int n = 0; n < 10 && ok == 1'b0; n++) begin
			@(posedge i_clk);
			#1;
			if (i_rdata_oe === 1'b1) begin
				ok = 1'b1;
				d = i_rdata;
			end
		end
		finish_cycle();
	endtask
endmodule

// file: bench/tb_banked_io_and_tx_control.sv
// Purpose: self-checking bench of the banked window and transmit control
// Assumes: base address fixed at 030h, host model drives the bus
// Notes: engine pulses are one cycle wide; self-sourced mostly held high
module tb_banked_io_and_tx_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] BASE = 12'h030;
	logic clk, rst, pcm, pdn, fr, fl, car, ss;
	logic [15:0] addr, wdata, rdata;
	logic sel_n, rd_n, wr_n, beh, bel, oe;
	logic [4:0] ev;
	logic [6:0] mode_out;
	logic act, pad0, abrt, f16, flc;
	int err_count, samples_checked;
	int k;
	logic [15:0] mv[7];
	logic [6:0] me[7];

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	bitc_host_model i_bitc_host_model (.i_clk(clk), .i_rdata(rdata),
		.i_rdata_oe(oe), .o_addr(addr), .o_wdata(wdata), .o_sel_n(sel_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_be_h(beh), .o_be_l(bel));

	bitc_top i_bitc_top (.I_CLK(clk), .I_RESET(rst), .I_PCMCIA_MODE(pcm),
		.I_POWERDOWN(pdn), .I_ADDR(addr), .I_REGISTER_SPACE_SELECT_N(sel_n),
		.I_IO_READ_STROBE_N(rd_n), .I_IO_WRITE_STROBE_N(wr_n),
		.I_BYTE_EN_HIGH(beh), .I_BYTE_EN_LOW(bel), .I_WDATA(wdata),
		.I_BASE_ADDR(BASE), .O_RDATA(rdata), .O_RDATA_OE(oe),
		.I_FRAME_READY(fr), .I_FRAME_BYTE_DONE(ev[0]), .I_FRAME_LAST(fl),
		.I_CARRIER(car), .I_PREAMBLE_END(ev[1]), .I_COLLISION(ev[2]),
		.I_LATE_COLLISION(ev[3]), .I_QUALITY_FAIL(ev[4]),
		.I_SELF_SOURCED(ss), .O_TX_ACTIVE(act), .O_TX_PAD_ZERO(pad0),
		.O_APPEND_CRC(mode_out[6]), .O_ABORT_NO_CRC(abrt),
		.O_SKIP_DEFER(mode_out[4]), .O_COLLISION_DETECT(mode_out[5]),
		.O_LOOP_BLOCK(mode_out[3]), .O_LOOP_ENDEC(mode_out[2]),
		.O_NET_TX_ENABLE(mode_out[1]), .O_ACCEPT_SELF(mode_out[0]),
		.O_SIXTEEN_COLLISION_FLAG(f16), .O_LATE_COLLISION_FLAG(flc));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] o, input logic [15:0] d);
		i_bitc_host_model.io_write({BASE, o}, d, 1'b1, 1'b1);
	endtask

	// a read that never answers ends the run
	task automatic rd(input logic [3:0] o, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		i_bitc_host_model.io_read({BASE, o}, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		if (ok !== 1'b1) report_and_stop();
		chk(d, e);
	endtask

	task automatic no_answer(input logic [15:0] a);
		logic [15:0] d;
		logic ok;
		i_bitc_host_model.io_read(a, d, ok);
		chk({15'h0000, ok}, 16'h0000);
	endtask

	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		#2 ev = m;
		@(posedge clk);
		#2 ev = 5'h00;
		repeat (3) @(posedge clk);
	endtask

	task automatic set_fr(input logic v);
		@(posedge clk);
		#2 fr = v;
		repeat (3) @(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		rd(4'hE, 16'h3300);
		rd(4'h0, 16'h0000);
		chk({9'h000, mode_out}, 16'h0062);
	endtask

	task automatic t_banks();
		wr(4'hE, 16'h0001);
		rd(4'hE, 16'h3301);
		wr(4'h0, 16'h0081);
		wr(4'hE, 16'h0004);
		rd(4'hE, 16'h3304);
		wr(4'h0, 16'h0081);
		wr(4'hE, 16'h0000);
		rd(4'h0, 16'h0000);
	endtask

	task automatic t_decode();
		i_bitc_host_model.io_write({12'h031, 4'h0}, 16'h0080, 1'b1, 1'b1);
		rd(4'h0, 16'h0000);
		no_answer({12'h031, 4'h0});
		@(posedge clk);
		#2 pcm = 1'b1;
		i_bitc_host_model.io_write({12'hABC, 4'h0}, 16'h0080, 1'b1, 1'b1);
		rd(4'h0, 16'h0080);
		@(posedge clk);
		#2 pdn = 1'b1;
		wr(4'h0, 16'h0000);
		no_answer({BASE, 4'hE});
		@(posedge clk);
		#2 pdn = 1'b0;
		rd(4'h0, 16'h0080);
		@(posedge clk);
		#2 pcm = 1'b0;
	endtask

	task automatic t_bytes();
		wr(4'h0, 16'h0000);
		i_bitc_host_model.io_write({BASE, 4'h1}, 16'h0081, 1'b0, 1'b1);
		rd(4'h0, 16'h8100);
		rd(4'h1, 16'h0081);
		i_bitc_host_model.io_write({BASE, 4'h0}, 16'hFF80, 1'b0, 1'b1);
		rd(4'h0, 16'h8180);
		rd(4'hF, 16'h0033);
		wr(4'h0, 16'h3D86);
		rd(4'h0, 16'h3D86);
	endtask

	task automatic t_modes();
		mv = '{16'h0000, 16'h0100, 16'h2000, 16'h2002, 16'h0002, 16'h8000,
			16'h0800};
		me = '{7'h62, 7'h22, 7'h68, 7'h48, 7'h44, 7'h53, 7'h63};
		for (k = 0; k < 7; k++) begin
			wr(4'h0, mv[k]);
			repeat (3) @(posedge clk);
			chk({9'h000, mode_out}, {9'h000, me[k]});
		end
		@(posedge clk);
		#2 ss = 1'b0;
		repeat (2) @(posedge clk);
		chk({15'h0000, mode_out[0]}, 16'h0000);
		// full duplex was left above: reset before transmitting again
		#2 rst = 1'b1;
		ss = 1'b1;
		repeat (2) @(posedge clk);
		#2 rst = 1'b0;
		chk({9'h000, mode_out}, 16'h0062);
		rd(4'h0, 16'h0000);
	endtask

	task automatic t_errors();
		wr(4'h0, 16'h0005);
		set_fr(1'b1);
		chk({15'h0000, mode_out[4]}, 16'h0001);
		pulse(5'h04);
		pulse(5'h08);
		rd(4'h0, 16'h0000);
		chk({15'h0000, flc}, 16'h0001);
		set_fr(1'b0);
		wr(4'h0, 16'h0001);
		chk({15'h0000, flc}, 16'h0000);
		set_fr(1'b1);
		for (k = 0; k < 15; k++) pulse(5'h04);
		chk({15'h0000, f16}, 16'h0000);
		pulse(5'h04);
		rd(4'h0, 16'h0000);
		chk({15'h0000, f16}, 16'h0001);
		set_fr(1'b0);
		wr(4'h0, 16'h1001);
		chk({15'h0000, f16}, 16'h0000);
		set_fr(1'b1);
		pulse(5'h10);
		rd(4'h0, 16'h1000);
		set_fr(1'b0);
		wr(4'h0, 16'h0001);
		set_fr(1'b1);
		pulse(5'h10);
		rd(4'h0, 16'h0001);
		set_fr(1'b0);
	endtask

	task automatic t_carrier();
		logic seen;
		seen = 1'b0;
		wr(4'h0, 16'h0401);
		set_fr(1'b1);
		@(posedge clk);
		#2 ev = 5'h02;
		for (k = 0; k < 6; k++) begin
			@(posedge clk);
			#2;
			if (abrt === 1'b1) seen = 1'b1;
			ev = 5'h00;
		end
		chk({15'h0000, seen}, 16'h0001);
		if (seen !== 1'b1) report_and_stop();
		rd(4'h0, 16'h0400);
		set_fr(1'b0);
	endtask

	task automatic t_stop();
		#2 car = 1'b1;
		wr(4'h0, 16'h0001);
		set_fr(1'b1);
		set_fr(1'b0);
		wr(4'h0, 16'h0000);
		chk({15'h0000, act}, 16'h0001);
		#2 fl = 1'b1;
		pulse(5'h01);
		chk({15'h0000, act}, 16'h0000);
	endtask

	// one-byte frame padded out to the minimum of 64 bytes
	task automatic t_pad();
		wr(4'h0, 16'h0081);
		set_fr(1'b1);
		set_fr(1'b0);
		#2 fl = 1'b1;
		pulse(5'h01);
		chk({15'h0000, pad0}, 16'h0001);
		for (k = 0; k < 62; k++) pulse(5'h01);
		chk({14'h0000, act, pad0}, 16'h0003);
		pulse(5'h01);
		chk({14'h0000, act, pad0}, 16'h0000);
	endtask

	initial begin
		rst = 1'b1;
		pcm = 1'b0;
		pdn = 1'b0;
		fr = 1'b0;
		fl = 1'b0;
		car = 1'b0;
		ss = 1'b1;
		ev = 5'h00;
		err_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk);
		#2 rst = 1'b0;
		t_reset();
		t_banks();
		t_decode();
		t_bytes();
		t_modes();
		t_errors();
		t_carrier();
		t_stop();
		t_pad();
		report_and_stop();
	end
endmodule
